// ### hdl/tppwm_pkg.sv
// Purpose: Constants, field layouts and carrier types for the three-phase PWM timing unit
// Assumes: 32-bit classic Wishbone register access, one aligned word per register
// Notes: Outputs active high, counters run at the instruction rate clock
//
// Contract
// R01 - Dead time between complementary pair edges
// R02 - Dead time equals register times two clocks
// R03 - Dead-time register is ten bits wide
// R04 - Zero dead time inserts no delay
// R05 - Mode bit 6 selects single/double update
// R06 - Reset clears mode bit, single update
// R07 - Single mode: one sync latches all values
// R08 - Sync edge copies segment control to output
// R09 - Double mode: extra mid-period sync latch
// R10 - Status bit 3 shows second half
// R11 - Sync pulse lasts width plus one
// R12 - Sync width resets to 0x27
// R13 - Three duty registers, one per phase
// R14 - Pulses centred about mid period
// R15 - Dead time shifts every edge equally
// R16 - Single mode on-time formulas, both sides
// R17 - On-times clamped between zero and period
// R18 - Double mode sums both half contributions
// R19 - No output until period and duties written
// R20 - Single mode first sync after 1.5 periods
// R21 - Double mode first sync after one period
// R22 - Period register counts half-period clocks
// R23 - Short pulse dropped, complement held on
// R24 - Six active-high outputs, three pairs
// R25 - Writes shadowed until next sync edge

package tppwm_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_HALF_PERIOD = 8'h00;
   localparam logic [7:0] ADR_DEAD_TIME = 8'h04;
   localparam logic [7:0] ADR_MIN_PULSE = 8'h08;
   localparam logic [7:0] ADR_SYNC_WIDTH = 8'h0C;
   localparam logic [7:0] ADR_DUTY_A = 8'h10;
   localparam logic [7:0] ADR_DUTY_B = 8'h14;
   localparam logic [7:0] ADR_DUTY_C = 8'h18;
   localparam logic [7:0] ADR_SEGMENT = 8'h1C;
   localparam logic [7:0] ADR_MODE_CTRL = 8'h20;
   localparam logic [7:0] ADR_SYS_STATUS = 8'h24;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int MODE_DOUBLE_BIT = 6;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_WAIT_BIT = 1;
   localparam int STAT_HALF_BIT = 3;
   localparam logic [15:0] HALF_PERIOD_RST = 16'h0000;
   localparam logic [9:0] DEAD_TIME_RST = 10'h000;
   localparam logic [15:0] MIN_PULSE_RST = 16'h0000;
   localparam logic [7:0] SYNC_WIDTH_RST = 8'h27;
   localparam logic [15:0] DUTY_RST = 16'h0000;
   localparam logic [8:0] SEGMENT_RST = 9'h000;
   localparam int NUM_PHASES = 3;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] tm;
      logic [9:0] dt;
      logic [15:0] pd;
      logic [7:0] sw;
      logic [2:0][15:0] duty;
      logic [8:0] seg;
      logic dbl;
   } tppwm_cfg_t;

   typedef struct packed {
      logic phase_a_high_out;
      logic phase_a_low_out;
      logic phase_b_high_out;
      logic phase_b_low_out;
      logic phase_c_high_out;
      logic phase_c_low_out;
   } tppwm_out_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b100
   } tppwm_state_t;

endpackage

// ### hdl/tppwm_timing_unit.sv
// Purpose: Three-phase centre-based PWM timing unit with dead time and sync pulse
// Assumes: clk is the instruction rate clock, rst synchronous active high
// Notes: Registers reached over classic Wishbone; outputs are registered

`timescale 1ns/1ps
`default_nettype none

module tppwm_timing_unit
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Timing unit outputs
   output tppwm_pkg::tppwm_out_t pwm_out,
   output logic period_sync_pulse,
   output logic [8:0] output_segment_active,
   output logic half_cycle
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   tppwm_pkg::tppwm_cfg_t shd;
   tppwm_pkg::tppwm_cfg_t act;
   tppwm_pkg::tppwm_state_t state;
   logic [3:0] written;
   logic [16:0] start_cnt;
   logic [16:0] start_delay;
   logic [15:0] pos;
   logic end_of_half;
   logic latch;
   logic [7:0] sync_cnt;
   logic bus_req;
   logic wr_en;
   logic [7:0] adr_word;
   logic [31:0] next_rdata;
   logic [31:0] next_wdat;
   logic [2:0] next_hi;
   logic [2:0] next_lo;

   // Byte-lane merge of a write into a register word
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Clamp a signed on-time into zero..half period
   function automatic logic [16:0] clamp_on(input logic signed [17:0] v, input logic [15:0] tm);
      logic [16:0] res;
      res = 17'h00000;
      if (v < 18'sh00000)
      begin
         res = 17'h00000;
      end
      else if (v > $signed({2'b00, tm}))
      begin
         res = {1'b0, tm};
      end
      else
      begin
         res = v[16:0];
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign adr_word = {wb_adr_i[7:2], 2'b00};
   // Write takes effect at the edge the master sees ack
   assign wr_en = bus_req & wb_we_i & wb_ack_o;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= bus_req & ~wb_ack_o;
      end
   end

   // Read decode; unmapped words read as zero
   always_comb
   begin
      next_rdata = 32'h00000000;
      if (adr_word == tppwm_pkg::ADR_HALF_PERIOD)
      begin
         next_rdata[15:0] = shd.tm;
      end
      else if (adr_word == tppwm_pkg::ADR_DEAD_TIME)
      begin
         next_rdata[9:0] = shd.dt;
      end
      else if (adr_word == tppwm_pkg::ADR_MIN_PULSE)
      begin
         next_rdata[15:0] = shd.pd;
      end
      else if (adr_word == tppwm_pkg::ADR_SYNC_WIDTH)
      begin
         next_rdata[7:0] = shd.sw;
      end
      else if (adr_word == tppwm_pkg::ADR_DUTY_A)
      begin
         next_rdata[15:0] = shd.duty[0];
      end
      else if (adr_word == tppwm_pkg::ADR_DUTY_B)
      begin
         next_rdata[15:0] = shd.duty[1];
      end
      else if (adr_word == tppwm_pkg::ADR_DUTY_C)
      begin
         next_rdata[15:0] = shd.duty[2];
      end
      else if (adr_word == tppwm_pkg::ADR_SEGMENT)
      begin
         next_rdata[8:0] = shd.seg;
      end
      else if (adr_word == tppwm_pkg::ADR_MODE_CTRL)
      begin
         next_rdata[tppwm_pkg::MODE_DOUBLE_BIT] = shd.dbl;
      end
      else if (adr_word == tppwm_pkg::ADR_SYS_STATUS)
      begin
         // R10 half status
         next_rdata[tppwm_pkg::STAT_HALF_BIT] = half_cycle;
         next_rdata[tppwm_pkg::STAT_RUN_BIT] = (state == tppwm_pkg::ST_RUN);
         next_rdata[tppwm_pkg::STAT_WAIT_BIT] = (state == tppwm_pkg::ST_WAIT);
      end
   end

   // Write word merged over the addressed register's current value
   assign next_wdat = merge_sel(next_rdata, wb_dat_i, wb_sel_i);

   // Read data captured as the ack is raised
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wb_dat_o <= 32'h00000000;
      end
      else if (bus_req & ~wb_ack_o & ~wb_we_i)
      begin
         wb_dat_o <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Shadow registers
   // ------------------------------------------------------------
   // R25 writes land in shadow only; R03 ten-bit dead time; R06 R12 reset values
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         shd.tm <= tppwm_pkg::HALF_PERIOD_RST;
         shd.dt <= tppwm_pkg::DEAD_TIME_RST;
         shd.pd <= tppwm_pkg::MIN_PULSE_RST;
         shd.sw <= tppwm_pkg::SYNC_WIDTH_RST;
         shd.duty <= {tppwm_pkg::DUTY_RST, tppwm_pkg::DUTY_RST, tppwm_pkg::DUTY_RST};
         shd.seg <= tppwm_pkg::SEGMENT_RST;
         shd.dbl <= 1'b0;
      end
      else if (wr_en)
      begin
         if (adr_word == tppwm_pkg::ADR_HALF_PERIOD)
         begin
            shd.tm <= next_wdat[15:0];
         end
         else if (adr_word == tppwm_pkg::ADR_DEAD_TIME)
         begin
            shd.dt <= next_wdat[9:0];
         end
         else if (adr_word == tppwm_pkg::ADR_MIN_PULSE)
         begin
            shd.pd <= next_wdat[15:0];
         end
         else if (adr_word == tppwm_pkg::ADR_SYNC_WIDTH)
         begin
            shd.sw <= next_wdat[7:0];
         end
         else if (adr_word == tppwm_pkg::ADR_DUTY_A)
         begin
            shd.duty[0] <= next_wdat[15:0];
         end
         else if (adr_word == tppwm_pkg::ADR_DUTY_B)
         begin
            shd.duty[1] <= next_wdat[15:0];
         end
         else if (adr_word == tppwm_pkg::ADR_DUTY_C)
         begin
            shd.duty[2] <= next_wdat[15:0];
         end
         else if (adr_word == tppwm_pkg::ADR_SEGMENT)
         begin
            shd.seg <= next_wdat[8:0];
         end
         else if (adr_word == tppwm_pkg::ADR_MODE_CTRL)
         begin
            // R05 mode select bit
            shd.dbl <= next_wdat[tppwm_pkg::MODE_DOUBLE_BIT];
         end
      end
   end

   // Marks for period and the three duty registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         written <= 4'h0;
      end
      else if (wr_en)
      begin
         if (adr_word == tppwm_pkg::ADR_HALF_PERIOD)
         begin
            written[0] <= 1'b1;
         end
         else if (adr_word == tppwm_pkg::ADR_DUTY_A)
         begin
            written[1] <= 1'b1;
         end
         else if (adr_word == tppwm_pkg::ADR_DUTY_B)
         begin
            written[2] <= 1'b1;
         end
         else if (adr_word == tppwm_pkg::ADR_DUTY_C)
         begin
            written[3] <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Start-up and period sequencing
   // ------------------------------------------------------------
   // R20 R21 first-sync delay, less the cycle spent in idle
   always_comb
   begin
      if (shd.dbl)
      begin
         start_delay = {1'b0, shd.tm};
      end
      else
      begin
         start_delay = 17'({1'b0, shd.tm} + {2'b00, shd.tm[15:1]});
      end
   end

   // R22 half-period position counter wraps at the period count
   assign end_of_half = (17'({1'b0, pos} + 17'h00001) >= {1'b0, act.tm});
   // R07 R09 latch at period start, and at mid period in double mode
   assign latch = ((state == tppwm_pkg::ST_WAIT) && (start_cnt == 17'h00000))
                  || ((state == tppwm_pkg::ST_RUN) && end_of_half && (half_cycle || shd.dbl));

   // R19 idle until period and duties are written, then wait, then run
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= tppwm_pkg::ST_IDLE;
         start_cnt <= 17'h00000;
      end
      else
      begin
         case (state)
            tppwm_pkg::ST_IDLE:
            begin
               if (&written)
               begin
                  state <= tppwm_pkg::ST_WAIT;
                  start_cnt <= (start_delay > 17'h00001) ? 17'(start_delay - 17'h00002) : 17'h00000;
               end
            end
            tppwm_pkg::ST_WAIT:
            begin
               if (start_cnt == 17'h00000)
               begin
                  state <= tppwm_pkg::ST_RUN;
               end
               else
               begin
                  start_cnt <= 17'(start_cnt - 17'h00001);
               end
            end
            tppwm_pkg::ST_RUN:
            begin
               state <= tppwm_pkg::ST_RUN;
            end
            default:
            begin
               state <= tppwm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Position and half flag; R10 clear in first half, set in second
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pos <= 16'h0000;
         half_cycle <= 1'b0;
      end
      else if (latch)
      begin
         pos <= 16'h0000;
         half_cycle <= (state == tppwm_pkg::ST_RUN) ? ~half_cycle : 1'b0;
      end
      else if ((state == tppwm_pkg::ST_RUN) && end_of_half)
      begin
         pos <= 16'h0000;
         half_cycle <= ~half_cycle;
      end
      else if (state == tppwm_pkg::ST_RUN)
      begin
         pos <= 16'(pos + 16'h0001);
      end
   end

   // R25 R07 R09 R08 shadow copied to active set on each sync edge
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         act <= '0;
         act.sw <= tppwm_pkg::SYNC_WIDTH_RST;
      end
      else if (latch)
      begin
         act <= shd;
      end
   end

   assign output_segment_active = act.seg;

   // R11 sync pulse lasts width plus one clock
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         period_sync_pulse <= 1'b0;
         sync_cnt <= 8'h00;
      end
      else if (latch)
      begin
         period_sync_pulse <= 1'b1;
         sync_cnt <= shd.sw;
      end
      else if (sync_cnt != 8'h00)
      begin
         sync_cnt <= 8'(sync_cnt - 8'h01);
      end
      else
      begin
         period_sync_pulse <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Per-phase waveform generation
   // ------------------------------------------------------------
   for (genvar g = 0; g < tppwm_pkg::NUM_PHASES; g++)
   begin : g_phase
      logic signed [17:0] raw_hi;
      logic signed [17:0] raw_lo;
      logic [16:0] on_hi;
      logic [16:0] on_lo;
      logic [16:0] eff_hi;
      logic [16:0] eff_lo;

      // R13 R16 R15 R01 R02 each edge moved by dead time from duty instant
      assign raw_hi = $signed({2'b00, act.duty[g]}) - $signed({8'h00, act.dt});
      assign raw_lo = $signed({2'b00, act.tm}) - $signed({2'b00, act.duty[g]}) - $signed({8'h00, act.dt});
      // R17 clamp to zero..half period
      assign on_hi = clamp_on(raw_hi, act.tm);
      assign on_lo = clamp_on(raw_lo, act.tm);

      // R23 short pulse dropped, complement held on
      always_comb
      begin
         eff_hi = on_hi;
         eff_lo = on_lo;
         if (on_hi < {1'b0, act.pd})
         begin
            eff_hi = 17'h00000;
            eff_lo = {1'b0, act.tm};
         end
         else if (on_lo < {1'b0, act.pd})
         begin
            eff_lo = 17'h00000;
            eff_hi = {1'b0, act.tm};
         end
      end

      // R14 R18 R04 high centred on period middle, halves use own values
      always_comb
      begin
         if (state != tppwm_pkg::ST_RUN)
         begin
            next_hi[g] = 1'b0;
            next_lo[g] = 1'b0;
         end
         else if (!half_cycle)
         begin
            next_hi[g] = ({1'b0, pos} >= 17'({1'b0, act.tm} - eff_hi));
            next_lo[g] = ({1'b0, pos} < eff_lo);
         end
         else
         begin
            next_hi[g] = ({1'b0, pos} < eff_hi);
            next_lo[g] = ({1'b0, pos} >= 17'({1'b0, act.tm} - eff_lo));
         end
      end
   end

   // R24 registered active-high pairs, off until running
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pwm_out <= '0;
      end
      else
      begin
         pwm_out.phase_a_high_out <= next_hi[0];
         pwm_out.phase_a_low_out <= next_lo[0];
         pwm_out.phase_b_high_out <= next_hi[1];
         pwm_out.phase_b_low_out <= next_lo[1];
         pwm_out.phase_c_high_out <= next_hi[2];
         pwm_out.phase_c_low_out <= next_lo[2];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [8:0] sync_len;

   // Counts high cycles of the sync pulse
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync_len <= 9'h000;
      end
      else if (period_sync_pulse)
      begin
         sync_len <= 9'(sync_len + 9'h001);
      end
      else
      begin
         sync_len <= 9'h000;
      end
   end

   sequence s_bus_request;
      bus_req && !wb_ack_o;
   endsequence

   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   AST_WB_ACK: assert property (s_bus_request |=> s_ack_once)
      else $error("Wishbone ack not a single cycle after request");

   AST_SYNC_WIDTH: assert property ($fell(period_sync_pulse) && !$past(latch) |-> // R11
                                    sync_len == 9'({1'b0, act.sw} + 9'h001))
      else $error("Sync pulse width differs from width register plus one");

   AST_MODE_RESET: assert property (disable iff (1'b0) rst |=> !shd.dbl) // R06
      else $error("Mode bit not cleared by reset");

   AST_SW_RESET: assert property (disable iff (1'b0) rst |=> shd.sw == tppwm_pkg::SYNC_WIDTH_RST) // R12
      else $error("Sync width not 0x27 after reset");

   AST_NO_OUT_EARLY: assert property (state != tppwm_pkg::ST_RUN |=> pwm_out == '0) // R19
      else $error("Output active before period and duties written");

   AST_LATCH_DUTY: assert property ($rose(period_sync_pulse) |-> act.duty == $past(shd.duty) // R25
                                    && output_segment_active == $past(shd.seg))
      else $error("Active values not taken from shadow at sync edge");

   AST_HALF_SINGLE: assert property ($rose(period_sync_pulse) && !act.dbl |-> !half_cycle) // R10
      else $error("Half flag set at start of single-mode period");

   AST_HALF_DOUBLE: assert property ($rose(period_sync_pulse) && act.dbl && $past(state) == // R09
                                     tppwm_pkg::ST_RUN |-> half_cycle != $past(half_cycle))
      else $error("Double-mode sync did not change half");

   AST_NO_OVERLAP_A: assert property (!(pwm_out.phase_a_high_out && pwm_out.phase_a_low_out)) // R01
      else $error("Phase A high and low both on");

   AST_DEAD_GAP_A: assert property ($fell(pwm_out.phase_a_high_out) && !act.dbl && act.dt != 10'h000 // R02
                                    && half_cycle && !latch |-> !pwm_out.phase_a_low_out[*2])
      else $error("Phase A low turned on inside dead time");

endmodule

`default_nettype wire

// ### test/tppwm_gate_model.sv
// Purpose: Gate drive stand-in that watches the six timing unit outputs
// Assumes: Outputs active high, one high and one low switch per leg
// Notes: Counts cycles in which both switches of any leg are on

`timescale 1ns/1ps
`default_nettype none

module tppwm_gate_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Drive levels from the timing unit
   input wire tppwm_pkg::tppwm_out_t pwm_out,
   // Shoot-through cycle count
   output var int shoot
);
   always_ff @(posedge clk)
   begin
      if (rst)
         shoot <= 0;
      else if ((pwm_out.phase_a_high_out & pwm_out.phase_a_low_out) |
               (pwm_out.phase_b_high_out & pwm_out.phase_b_low_out) |
               (pwm_out.phase_c_high_out & pwm_out.phase_c_low_out))
         shoot <= shoot + 1;
   end
endmodule

`default_nettype wire

// ### test/testbench.sv
// Purpose: Self-checking bench for the three-phase PWM timing unit
// Assumes: Half period 8 clocks keeps each scenario short
// Notes: Registers reached by classic Wishbone single cycles

`timescale 1ns/1ps
`default_nettype none

`define CHK(a,b,m) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("mismatch %0t %s", $time, m); end end

module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdata;
   logic [31:0] rd;
   logic ack;
   logic sync;
   logic sp_q = 1'b0;
   logic [8:0] seg;
   logic half_cycle;
   logic h1;
   tppwm_pkg::tppwm_out_t pwm_out;
   int shoot;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int hi[6];
   int hc;
   int fa;
   int n;
   int w;

   // Design and gate drive stand-in
   tppwm_timing_unit i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack),
      .pwm_out(pwm_out), .period_sync_pulse(sync), .output_segment_active(seg), .half_cycle(half_cycle));
   tppwm_gate_model i_gate (.clk(clk), .rst(rst), .pwm_out(pwm_out), .shoot(shoot));

   // Clock, sync edge history and hang guard
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      sp_q <= sync;
      cycles++;
      if (cycles > 5000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // Bus and timing helpers
   // ------------------------------------------------------------
   task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_en;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdata;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // Counts edges up to the next sync rise, or lim
   task automatic wait_rise(input int lim, output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (!(sync === 1'b1 && sp_q === 1'b0) && k < lim);
   endtask

   // Samples one period of outputs after a sync rise
   task automatic measure();
      logic [5:0] v;
      wait_rise(100, n);
      hi = '{default:0};
      hc = 0;
      fa = -1;
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clk);
         #1;
         v = pwm_out;
         for (int i = 0; i < 6; i++)
            hi[i] += v[i];
         hc += half_cycle;
         if (v[5] && fa < 0)
            fa = k;
      end
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_vals();
      do_reset();
      bus(1'b0, tppwm_pkg::ADR_SYNC_WIDTH, 32'h0, rd);
      `CHK(rd[7:0], 8'h27, "sync width reset")
      bus(1'b0, tppwm_pkg::ADR_MODE_CTRL, 32'h0, rd);
      `CHK(rd[6], 1'b0, "mode reset")
      bus(1'b0, 8'h40, 32'h0, rd);
      `CHK(rd, 32'h0, "unmapped read")
      wr(tppwm_pkg::ADR_HALF_PERIOD, 32'h8);
      wr(tppwm_pkg::ADR_DUTY_A, 32'h5);
      wait_rise(40, n);
      `CHK(n, 40, "sync before setup")
      `CHK(pwm_out, 6'h00, "outputs before setup")
      $display("test reset_vals done");
   endtask

   task automatic t_single();
      do_reset();
      wr(tppwm_pkg::ADR_SYNC_WIDTH, 32'h2);
      wr(tppwm_pkg::ADR_DEAD_TIME, 32'h1);
      wr(tppwm_pkg::ADR_DUTY_A, 32'h5);
      wr(tppwm_pkg::ADR_DUTY_B, 32'h0);
      wr(tppwm_pkg::ADR_DUTY_C, 32'h9);
      wr(tppwm_pkg::ADR_HALF_PERIOD, 32'h8);
      wait_rise(100, n);
      `CHK(n, 12, "first sync delay")
      wait_rise(100, n);
      `CHK(n, 16, "sync interval")
      w = 0;
      while (sync === 1'b1 && w < 300)
      begin
         w++;
         @(posedge clk);
         #1;
      end
      `CHK(w, 3, "sync width")
      measure();
      `CHK(hi[5], 8, "a high time")
      `CHK(hi[4], 4, "a low time")
      `CHK(fa, 4, "a high centred")
      `CHK(hi[3] + hi[2], 14, "b clamp low")
      `CHK(hi[1] - hi[0], 16, "c clamp high")
      `CHK(hc, 8, "half flag")
      `CHK(shoot, 0, "leg overlap")
      $display("test single done");
   endtask

   task automatic t_minpulse();
      wait_rise(100, n);
      wr(tppwm_pkg::ADR_MIN_PULSE, 32'h3);
      wr(tppwm_pkg::ADR_DEAD_TIME, 32'h0);
      wr(tppwm_pkg::ADR_DUTY_A, 32'h2);
      wr(tppwm_pkg::ADR_DUTY_B, 32'h3);
      measure();
      `CHK(hi[5] - hi[4], -16, "a dropped")
      `CHK(hi[3] * 100 + hi[2], 610, "b no gap")
      $display("test minpulse done");
   endtask

   task automatic t_segment();
      wait_rise(100, n);
      wr(tppwm_pkg::ADR_SEGMENT, 32'h1A7);
      `CHK(seg, 9'h000, "segment early")
      wait_rise(100, n);
      @(posedge clk);
      #1;
      `CHK(seg, 9'h1A7, "segment latched")
      $display("test segment done");
   endtask

   task automatic t_double();
      do_reset();
      wr(tppwm_pkg::ADR_MODE_CTRL, 32'h40);
      wr(tppwm_pkg::ADR_SYNC_WIDTH, 32'h2);
      wr(tppwm_pkg::ADR_DUTY_A, 32'h5);
      wr(tppwm_pkg::ADR_DUTY_B, 32'h5);
      wr(tppwm_pkg::ADR_DUTY_C, 32'h5);
      wr(tppwm_pkg::ADR_HALF_PERIOD, 32'h8);
      wait_rise(100, n);
      `CHK(n, 8, "double first sync")
      wait_rise(100, n);
      `CHK(n, 8, "mid sync")
      repeat (4) @(posedge clk);
      h1 = half_cycle;
      bus(1'b0, tppwm_pkg::ADR_SYS_STATUS, 32'h0, rd);
      `CHK(rd[3:0], 4'h9, "status half bit")
      wait_rise(100, n);
      repeat (4) @(posedge clk);
      `CHK(h1 ^ half_cycle, 1'b1, "half toggles")
      $display("test double done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      t_reset_vals();
      t_single();
      t_minpulse();
      t_segment();
      t_double();
      end_of_test();
   end
endmodule

`default_nettype wire
